/* File: fifo_pkg.sv */
package fifo_pkg;

  localparam int DATA_W = 18;
  localparam int ROW_AW = 8;
  localparam int LVL_W = 13;
  localparam int LANE_W = 4;
  localparam int OFF_W = 5;
  localparam int REG_W = 16;
  localparam int ADDR_W = 3;
  localparam int EV_N = 4;
  localparam int SYNC_W = 31;

  // Width select codes
  localparam logic [2:0] WSEL_X1 = 3'h0;
  localparam logic [2:0] WSEL_X2 = 3'h1;
  localparam logic [2:0] WSEL_X4 = 3'h2;
  localparam logic [2:0] WSEL_X9 = 3'h3;
  localparam logic [2:0] WSEL_X18 = 3'h4;

  // Physical capacity in bits; 9 and 18 wide geometries use the extra bits
  localparam logic [LVL_W:0] CAP_NARROW_BITS = 14'h1000;
  localparam logic [LVL_W:0] CAP_WIDE_BITS = 14'h1200;

  // Register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_AF_THR = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_AE_THR = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 3'h5;

  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_WEN_HI_BIT = 1;
  localparam int CTRL_REN_HI_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h5;
  localparam logic [LVL_W-1:0] AF_THR_RESET = 13'h1000;
  localparam logic [LVL_W-1:0] AE_THR_RESET = 13'h0000;
  localparam logic [EV_N-1:0] MASK_RESET = 4'h0;

  localparam int EV_OVERFLOW = 0;
  localparam int EV_UNDERFLOW = 1;
  localparam int EV_ALMOST_FULL = 2;
  localparam int EV_ALMOST_EMPTY = 3;

  function automatic logic [OFF_W-1:0] geo_bits(input logic [2:0] sel);
    unique case (sel)
      WSEL_X1: geo_bits = 5'h01;
      WSEL_X2: geo_bits = 5'h02;
      WSEL_X4: geo_bits = 5'h04;
      WSEL_X9: geo_bits = 5'h09;
      WSEL_X18: geo_bits = 5'h12;
      default: geo_bits = 5'h00;
    endcase
  endfunction : geo_bits

  function automatic logic [LANE_W-1:0] geo_last_lane(input logic [2:0] sel);
    unique case (sel)
      WSEL_X1: geo_last_lane = 4'hf;
      WSEL_X2: geo_last_lane = 4'h7;
      WSEL_X4: geo_last_lane = 4'h3;
      WSEL_X9: geo_last_lane = 4'h1;
      default: geo_last_lane = 4'h0;
    endcase
  endfunction : geo_last_lane

endpackage : fifo_pkg

/* File: mem_if.sv */
`timescale 1ns/1ps
interface mem_if;
  logic we;
  logic [7:0] waddr;
  logic [17:0] wdata;
  logic [17:0] wmask;
  logic re;
  logic [7:0] raddr;
  logic [17:0] rdata;
  modport ctrl (output we, waddr, wdata, wmask, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, wmask, re, raddr, output rdata);
endinterface : mem_if

/* File: fifo_bit_ram.sv */
`timescale 1ns/1ps
module fifo_bit_ram (
  input wire logic clk,
  mem_if.mem port
);
  logic [17:0] ram [0:255];
  logic [17:0] rdata_q;

  // No reset on the array: contents survive a reset
  always_ff @(posedge clk) begin
    if (port.we) begin
      ram[port.waddr] <= (ram[port.waddr] & ~port.wmask) | (port.wdata & port.wmask);
    end
    if (port.re) begin
      rdata_q <= ram[port.raddr];
    end
  end

  assign port.rdata = rdata_q;
endmodule : fifo_bit_ram

/* File: embedded_fifo_element.sv */
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Operation
// - width select codes 0..4 give 4kx1 to 256x18; codes 5..7 reserved.
// - each port acts only while its active-low select is low.
// - read data hold their last value while the read select is high.
// - write enable active low, read enable active high by default; both configurable.
// - writes follow the write clock, reads follow the read clock.
// - pipeline select low: read data appear in the read cycle itself.
// - pipeline select high: read data appear one read clock later.
// - reset clears pointers, level, full flags and output hold registers, and sets the empty flags.
// - reset leaves the memory array untouched.
// - while reset is held no read or write happens.
// - write data bus is 18 bits; only low bits of the width count.
// - almost-full and almost-empty thresholds are counted in data bits.
// - a control bit chooses halting or free-running pointers at full/empty.
// - full marks the physical capacity of the selected geometry.
module embedded_fifo_element (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WCLK_PIN,
  input wire logic RCLK_PIN,
  input wire logic WRITE_PORT_SEL_N,
  input wire logic READ_PORT_SEL_N,
  input wire logic WRITE_EN,
  input wire logic READ_EN,
  input wire logic [fifo_pkg::DATA_W-1:0] WRITE_DATA_BUS,
  input wire logic [2:0] WRITE_WIDTH_SEL,
  input wire logic [2:0] READ_WIDTH_SEL,
  input wire logic READ_PIPELINE_SEL,
  input wire logic [fifo_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [fifo_pkg::REG_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [fifo_pkg::REG_W-1:0] REG_RDATA,
  output logic [fifo_pkg::DATA_W-1:0] READ_DATA,
  output logic FULL,
  output logic ALMOST_FULL,
  output logic EMPTY,
  output logic ALMOST_EMPTY,
  output logic IRQ
);
  import fifo_pkg::*;

  mem_if mem ();

  fifo_bit_ram u_ram (
    .clk(REF_CLK),
    .port(mem.mem)
  );

  // Port pins arrive from foreign clocks: two flops before any logic
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic wclk_q;
  logic rclk_q;

  assign pins = {WCLK_PIN, RCLK_PIN, WRITE_PORT_SEL_N, READ_PORT_SEL_N, WRITE_EN, READ_EN,
                 WRITE_DATA_BUS, WRITE_WIDTH_SEL, READ_WIDTH_SEL, READ_PIPELINE_SEL};

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s1_q <= '0;
      s2_q <= '0;
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      wclk_q <= s2_q[30];
      rclk_q <= s2_q[29];
    end
  end

  logic wsel_n;
  logic rsel_n;
  logic wen;
  logic ren;
  logic [DATA_W-1:0] wdata;
  logic [2:0] wgeo;
  logic [2:0] rgeo;
  logic read_pipeline_sel;

  assign wsel_n = s2_q[28];
  assign rsel_n = s2_q[27];
  assign wen = s2_q[26];
  assign ren = s2_q[25];
  assign wdata = s2_q[24:7];
  assign wgeo = s2_q[6:4];
  assign rgeo = s2_q[3:1];
  assign read_pipeline_sel = s2_q[0];

  // Control state
  logic [ROW_AW-1:0] wrow_q, wrow_d, rrow_q, rrow_d;
  logic [LANE_W-1:0] wlane_q, wlane_d, rlane_q, rlane_d;
  logic [LVL_W-1:0] level_q, level_d;
  logic fetch_q, fetch_d;
  logic fetch_pipe_q, fetch_pipe_d;
  logic [OFF_W-1:0] fetch_off_q, fetch_off_d;
  logic [OFF_W-1:0] fetch_bits_q, fetch_bits_d;
  logic [DATA_W-1:0] stage_q, stage_d;
  logic [DATA_W-1:0] rd_out_q, rd_out_d;
  logic full_q, full_d, afull_q, afull_d, empty_q, empty_d, aempty_q, aempty_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic [LVL_W-1:0] af_thr_q, af_thr_d, ae_thr_q, ae_thr_d;
  logic [EV_N-1:0] status_q, status_d, mask_q, mask_d;
  logic irq_q, irq_d;
  logic [REG_W-1:0] rdata_q, rdata_d;

  logic wtick, rtick, wr_req, rd_req, do_wr, do_rd, full_now, empty_now;
  logic [OFF_W-1:0] wbits, rbits, woff, roff;
  logic [LVL_W:0] cap, sum, lvl_tmp;
  logic [DATA_W-1:0] wmask_v, fetched;
  logic [EV_N-1:0] events;

  always_comb begin
    wtick = s2_q[30] & ~wclk_q;
    rtick = s2_q[29] & ~rclk_q;
    wbits = geo_bits(wgeo);
    rbits = geo_bits(rgeo);
    woff = OFF_W'(wlane_q * wbits);
    roff = OFF_W'(rlane_q * rbits);
    cap = (wgeo == WSEL_X9 || wgeo == WSEL_X18) ? CAP_WIDE_BITS : CAP_NARROW_BITS;
    // Reserved codes give zero width and so never start an operation
    wr_req = wtick & ~wsel_n & (wen == ctrl_q[CTRL_WEN_HI_BIT]) & (wbits != '0);
    rd_req = rtick & ~rsel_n & (ren == ctrl_q[CTRL_REN_HI_BIT]) & (rbits != '0);
    full_now = ({1'b0, level_q} + {{(LVL_W + 1 - OFF_W){1'b0}}, wbits}) > {1'b0, cap};
    empty_now = {1'b0, level_q} < {{(LVL_W + 1 - OFF_W){1'b0}}, rbits};
    do_wr = wr_req & ~(full_now & ctrl_q[CTRL_HALT_BIT]);
    do_rd = rd_req & ~(empty_now & ctrl_q[CTRL_HALT_BIT]);

    // Write and read side pointers, lanes within an 18-bit row
    wrow_d = wrow_q;
    wlane_d = wlane_q;
    if (do_wr) begin
      if (wlane_q >= geo_last_lane(wgeo)) begin
        wlane_d = '0;
        wrow_d = ROW_AW'(wrow_q + 1'b1);
      end else begin
        wlane_d = LANE_W'(wlane_q + 1'b1);
      end
    end
    rrow_d = rrow_q;
    rlane_d = rlane_q;
    if (do_rd) begin
      if (rlane_q >= geo_last_lane(rgeo)) begin
        rlane_d = '0;
        rrow_d = ROW_AW'(rrow_q + 1'b1);
      end else begin
        rlane_d = LANE_W'(rlane_q + 1'b1);
      end
    end

    // Fill level in bits, clamped when pointers run free
    sum = {1'b0, level_q} + (do_wr ? {{(LVL_W + 1 - OFF_W){1'b0}}, wbits} : '0);
    lvl_tmp = '0;
    if (do_rd && sum > {{(LVL_W + 1 - OFF_W){1'b0}}, rbits}) begin
      lvl_tmp = sum - {{(LVL_W + 1 - OFF_W){1'b0}}, rbits};
    end else if (!do_rd) begin
      lvl_tmp = sum;
    end
    if (lvl_tmp > cap) begin
      lvl_tmp = cap;
    end
    level_d = lvl_tmp[LVL_W-1:0];

    // Flags from the next level; full side by write geometry, empty side by read
    full_d = ({1'b0, level_d} + {{(LVL_W + 1 - OFF_W){1'b0}}, wbits}) > {1'b0, cap};
    afull_d = level_d >= af_thr_q;
    empty_d = {1'b0, level_d} < {{(LVL_W + 1 - OFF_W){1'b0}}, rbits};
    aempty_d = level_d <= ae_thr_q;

    // Memory access: row write with lane mask, row read then lane select
    wmask_v = DATA_W'(((18'h1 << wbits) - 18'h1) << woff);
    mem.we = do_wr;
    mem.waddr = wrow_q;
    mem.wdata = DATA_W'(wdata << woff) & wmask_v;
    mem.wmask = wmask_v;
    mem.re = do_rd;
    mem.raddr = rrow_q;
    fetch_d = do_rd;
    fetch_pipe_d = read_pipeline_sel;
    fetch_off_d = roff;
    fetch_bits_d = rbits;
    fetched = (mem.rdata >> fetch_off_q) & DATA_W'((18'h1 << fetch_bits_q) - 18'h1);

    // Outputs change only for a selected read port
    stage_d = stage_q;
    rd_out_d = rd_out_q;
    if (rtick && !rsel_n && read_pipeline_sel) begin
      rd_out_d = stage_q;
    end
    if (fetch_q) begin
      if (fetch_pipe_q) begin
        stage_d = fetched;
      end else begin
        rd_out_d = fetched;
      end
    end

    // Register file
    ctrl_d = ctrl_q;
    af_thr_d = af_thr_q;
    ae_thr_d = ae_thr_q;
    mask_d = mask_q;
    events = '0;
    events[EV_OVERFLOW] = wr_req & full_now;
    events[EV_UNDERFLOW] = rd_req & empty_now;
    events[EV_ALMOST_FULL] = afull_d & ~afull_q;
    events[EV_ALMOST_EMPTY] = aempty_d & ~aempty_q;
    status_d = status_q;
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_CTRL: ctrl_d = REG_WDATA[2:0];
        ADDR_AF_THR: af_thr_d = REG_WDATA[LVL_W-1:0];
        ADDR_AE_THR: ae_thr_d = REG_WDATA[LVL_W-1:0];
        ADDR_STATUS: status_d = status_q & ~REG_WDATA[EV_N-1:0];
        ADDR_MASK: mask_d = REG_WDATA[EV_N-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    status_d = status_d | events;
    irq_d = |(status_d & mask_d);
    rdata_d = '0;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_CTRL: rdata_d = {13'h0000, ctrl_q};
        ADDR_AF_THR: rdata_d = {3'h0, af_thr_q};
        ADDR_AE_THR: rdata_d = {3'h0, ae_thr_q};
        ADDR_STATUS: rdata_d = {12'h000, status_q};
        ADDR_MASK: rdata_d = {12'h000, mask_q};
        ADDR_LEVEL: rdata_d = {full_q, empty_q, 1'b0, level_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      // Array is not part of this reset
      wrow_q <= '0;
      wlane_q <= '0;
      rrow_q <= '0;
      rlane_q <= '0;
      level_q <= '0;
      fetch_q <= 1'b0;
      fetch_pipe_q <= 1'b0;
      fetch_off_q <= '0;
      fetch_bits_q <= '0;
      stage_q <= '0;
      rd_out_q <= '0;
      full_q <= 1'b0;
      afull_q <= 1'b0;
      empty_q <= 1'b1;
      aempty_q <= 1'b1;
      ctrl_q <= CTRL_RESET;
      af_thr_q <= AF_THR_RESET;
      ae_thr_q <= AE_THR_RESET;
      status_q <= '0;
      mask_q <= MASK_RESET;
      irq_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      wrow_q <= wrow_d;
      wlane_q <= wlane_d;
      rrow_q <= rrow_d;
      rlane_q <= rlane_d;
      level_q <= level_d;
      fetch_q <= fetch_d;
      fetch_pipe_q <= fetch_pipe_d;
      fetch_off_q <= fetch_off_d;
      fetch_bits_q <= fetch_bits_d;
      stage_q <= stage_d;
      rd_out_q <= rd_out_d;
      full_q <= full_d;
      afull_q <= afull_d;
      empty_q <= empty_d;
      aempty_q <= aempty_d;
      ctrl_q <= ctrl_d;
      af_thr_q <= af_thr_d;
      ae_thr_q <= ae_thr_d;
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign READ_DATA = rd_out_q;
  assign FULL = full_q;
  assign ALMOST_FULL = afull_q;
  assign EMPTY = empty_q;
  assign ALMOST_EMPTY = aempty_q;
  assign IRQ = irq_q;
  assign REG_RDATA = rdata_q;
endmodule : embedded_fifo_element

/* File: fifo_properties.sv */
`timescale 1ns/1ps
module fifo_properties (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WRITE_PORT_SEL_N,
  input wire logic READ_PORT_SEL_N,
  input wire logic [2:0] WRITE_WIDTH_SEL,
  input wire logic [2:0] READ_WIDTH_SEL,
  input wire logic [fifo_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [fifo_pkg::REG_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [fifo_pkg::REG_W-1:0] REG_RDATA,
  input wire logic [fifo_pkg::DATA_W-1:0] READ_DATA,
  input wire logic FULL,
  input wire logic ALMOST_FULL,
  input wire logic EMPTY,
  input wire logic ALMOST_EMPTY,
  input wire logic IRQ
);
  import fifo_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // Both ports parked and nothing reconfigured
  sequence idle_s;
    WRITE_PORT_SEL_N && READ_PORT_SEL_N && !REG_WR && $stable(WRITE_WIDTH_SEL)
      && $stable(READ_WIDTH_SEL);
  endsequence
  sequence ae_all_s;
    REG_WR && REG_ADDR == ADDR_AE_THR && REG_WDATA[12:0] == 13'h1fff;
  endsequence
  sequence af_zero_s;
    REG_WR && REG_ADDR == ADDR_AF_THR && REG_WDATA[12:0] == 13'h0000;
  endsequence

  AST_RESET_OUTS: assert property (disable iff (1'b0) !RST_N |=> READ_DATA == '0 && !FULL
    && !ALMOST_FULL && EMPTY && ALMOST_EMPTY && !IRQ) else $error("outputs not cleared by reset");
  AST_READ_FREEZE: assert property (READ_PORT_SEL_N [*6] |=> $stable(READ_DATA))
    else $error("read data moved while port deselected");
  AST_IDLE_FLAGS: assert property (idle_s [*8] |=> $stable({FULL, ALMOST_FULL, EMPTY,
    ALMOST_EMPTY})) else $error("flags moved with both ports deselected");
  AST_REG_QUIET: assert property (!REG_RD |=> REG_RDATA == '0)
    else $error("register read data outside read answer");
  AST_REG_UNMAPPED: assert property (REG_RD && REG_ADDR > ADDR_LEVEL |=> REG_RDATA == '0)
    else $error("unmapped register read not zero");
  AST_AE_THR: assert property (ae_all_s |-> ##2 ALMOST_EMPTY)
    else $error("almost empty missing at full threshold");
  AST_AF_THR: assert property (af_zero_s |-> ##2 ALMOST_FULL)
    else $error("almost full missing at zero threshold");
  AST_MASK_OFF: assert property (REG_WR && REG_ADDR == ADDR_MASK && REG_WDATA[3:0] == 4'h0
    |=> ##1 !IRQ) else $error("interrupt with all events masked");
endmodule : fifo_properties

bind embedded_fifo_element fifo_properties fifo_properties_i (.*);

/* File: fabric_port_model.sv */
`timescale 1ns/1ps
module fabric_port_model (
  input wire logic clk,
  output logic wclk,
  output logic rclk,
  output logic wsel_n,
  output logic rsel_n,
  output logic wen,
  output logic ren,
  output logic [fifo_pkg::DATA_W-1:0] wdata,
  output logic [2:0] wwidth,
  output logic [2:0] rwidth,
  output logic pipe
);
  import fifo_pkg::*;
  initial begin
    {wclk, rclk, ren, wdata, pipe} = '0;
    {wsel_n, rsel_n, wen} = 3'h7;
    wwidth = WSEL_X18;
    rwidth = WSEL_X18;
  end

  task cfg(input logic [2:0] w, input logic [2:0] r, input logic p);
    @(posedge clk);
    wwidth <= w;
    rwidth <= r;
    pipe <= p;
    #1;
  endtask : cfg

  // Port clocks stand still between transfers
  task push(input logic [17:0] d, input logic [4:0] bits, input logic en);
    @(posedge clk);
    wsel_n <= 1'b0;
    wen <= en;
    wdata <= d & ((18'h1 << bits) - 18'h1);
    repeat (3) @(posedge clk);
    wclk <= 1'b1;
    repeat (3) @(posedge clk);
    wclk <= 1'b0;
    repeat (3) @(posedge clk);
    wsel_n <= 1'b1;
    wen <= 1'b1;
    wdata <= ~wdata;
    #1;
  endtask : push

  task pop(input logic sel_n);
    @(posedge clk);
    rsel_n <= sel_n;
    ren <= 1'b1;
    repeat (3) @(posedge clk);
    // Read clock rises only while the write clock rests low
    rclk <= 1'b1;
    repeat (3) @(posedge clk);
    rclk <= 1'b0;
    repeat (3) @(posedge clk);
    rsel_n <= 1'b1;
    ren <= 1'b0;
    #1;
  endtask : pop
endmodule : fabric_port_model

/* File: embedded_fifo_element_tb_top.sv */
`timescale 1ns/1ps
module embedded_fifo_element_tb_top;
  import fifo_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  wire wclk, rclk, wsel_n, rsel_n, wen, ren, pipe;
  wire [17:0] wdata;
  wire [2:0] wwidth, rwidth;
  logic [15:0] reg_rdata;
  logic [17:0] read_data;
  logic full, almost_full, empty, almost_empty, irq;
  int n_errors = 0;
  int samples_checked = 0;
  logic [17:0] pat [3] = '{18'h2a5c3, 18'h15a3c, 18'h3ffff};
  logic [4:0] wb [4] = '{5'd1, 5'd2, 5'd4, 5'd9};

  always #50 ref_clk = ~ref_clk;

  embedded_fifo_element embedded_fifo_element_i (.REF_CLK(ref_clk), .RST_N(rst_n),
    .WCLK_PIN(wclk), .RCLK_PIN(rclk), .WRITE_PORT_SEL_N(wsel_n), .READ_PORT_SEL_N(rsel_n),
    .WRITE_EN(wen), .READ_EN(ren), .WRITE_DATA_BUS(wdata), .WRITE_WIDTH_SEL(wwidth),
    .READ_WIDTH_SEL(rwidth), .READ_PIPELINE_SEL(pipe), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .READ_DATA(read_data), .FULL(full), .ALMOST_FULL(almost_full), .EMPTY(empty),
    .ALMOST_EMPTY(almost_empty), .IRQ(irq));

  fabric_port_model fabric_port_model_i (.clk(ref_clk), .wclk(wclk), .rclk(rclk),
    .wsel_n(wsel_n), .rsel_n(rsel_n), .wen(wen), .ren(ren), .wdata(wdata),
    .wwidth(wwidth), .rwidth(rwidth), .pipe(pipe));

  task chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task reg_wr_t(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t

  task reg_chk(input string name, input logic [2:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, 18'(exp), 18'(reg_rdata));
  endtask : reg_chk

  // Lane pointers keep their position over a geometry change, so restart them
  task reset_pulse;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : reset_pulse

  task conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end

  initial begin
    rst_n <= 1'b0;
    reg_addr <= '0;
    reg_wdata <= '0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("flags", 18'h3, 18'({full, almost_full, empty, almost_empty}));
    reg_chk("ctrl", ADDR_CTRL, 16'h0005);
    reg_chk("af_thr", ADDR_AF_THR, 16'h1000);
    reg_chk("ae_thr", ADDR_AE_THR, 16'h0000);
    reg_chk("mask", ADDR_MASK, 16'h0000);
    reg_chk("unmapped", 3'h6, 16'h0000);
    foreach (pat[i]) fabric_port_model_i.push(pat[i], 5'd18, 1'b0);
    reg_chk("level", ADDR_LEVEL, 16'h0036);
    foreach (pat[i]) begin
      fabric_port_model_i.pop(1'b0);
      chk("rd", pat[i], read_data);
    end
    fabric_port_model_i.push(18'h01234, 5'd18, 1'b1);
    reg_chk("level", ADDR_LEVEL, 16'h4000);
    reg_wr_t(ADDR_CTRL, 16'h0007);
    fabric_port_model_i.push(18'h01234, 5'd18, 1'b1);
    reg_wr_t(ADDR_CTRL, 16'h0005);
    fabric_port_model_i.pop(1'b1);
    chk("frozen", pat[2], read_data);
    fabric_port_model_i.pop(1'b0);
    chk("rd", 18'h01234, read_data);
    fabric_port_model_i.cfg(3'h5, WSEL_X18, 1'b0);
    fabric_port_model_i.push(18'h00001, 5'd18, 1'b0);
    reg_chk("level", ADDR_LEVEL, 16'h4000);
    for (int c = 0; c < 4; c++) begin
      reset_pulse();
      fabric_port_model_i.cfg(3'(c), 3'(c), 1'b0);
      fabric_port_model_i.push(18'h2b5a7, wb[c], 1'b0);
      fabric_port_model_i.pop(1'b0);
      chk("width", 18'h2b5a7 & ~(18'h3ffff << wb[c]), read_data);
    end
    reset_pulse();
    fabric_port_model_i.cfg(WSEL_X9, WSEL_X18, 1'b0);
    fabric_port_model_i.push(18'h001a5, 5'd9, 1'b0);
    fabric_port_model_i.push(18'h000c3, 5'd9, 1'b0);
    fabric_port_model_i.pop(1'b0);
    chk("mixed", {9'h0c3, 9'h1a5}, read_data);
    fabric_port_model_i.cfg(WSEL_X18, WSEL_X18, 1'b1);
    fabric_port_model_i.push(pat[0], 5'd18, 1'b0);
    fabric_port_model_i.push(pat[1], 5'd18, 1'b0);
    fabric_port_model_i.pop(1'b0);
    fabric_port_model_i.pop(1'b0);
    chk("piped", pat[0], read_data);
    reg_wr_t(ADDR_STATUS, 16'h000f);
    fabric_port_model_i.pop(1'b0);
    reg_chk("status", ADDR_STATUS, 16'h0002);
    reg_wr_t(ADDR_MASK, 16'h0004);
    reg_wr_t(ADDR_AF_THR, 16'h0000);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("irq", 18'h1, 18'(irq));
    reg_wr_t(ADDR_STATUS, 16'h0004);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq", 18'h0, 18'(irq));
    reg_wr_t(ADDR_AF_THR, 16'h1000);
    reg_wr_t(ADDR_MASK, 16'h0000);
    fabric_port_model_i.cfg(WSEL_X18, WSEL_X18, 1'b0);
    reg_wr_t(ADDR_STATUS, 16'h000f);
    for (int i = 0; i < 255; i++) fabric_port_model_i.push(18'(i), 5'd18, 1'b0);
    chk("full", 18'h0, 18'(full));
    fabric_port_model_i.push(18'h3ffff, 5'd18, 1'b0);
    chk("full", 18'h1, 18'(full));
    fabric_port_model_i.push(18'h00005, 5'd18, 1'b0);
    reg_chk("status", ADDR_STATUS, 16'h0005);
    reg_chk("level", ADDR_LEVEL, 16'h9200);
    // Free-running pointers: a write at full overwrites the oldest row
    reg_wr_t(ADDR_CTRL, 16'h0004);
    fabric_port_model_i.push(18'h02468, 5'd18, 1'b0);
    fabric_port_model_i.pop(1'b0);
    chk("wrap", 18'h02468, read_data);
    reg_wr_t(ADDR_AE_THR, 16'h1fff);
    reg_wr_t(ADDR_AE_THR, 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    fabric_port_model_i.push(18'h00077, 5'd18, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("flags", 18'h3, 18'({full, almost_full, empty, almost_empty}));
    chk("rdata", 18'h0, read_data);
    reg_chk("level", ADDR_LEVEL, 16'h4000);
    conclude();
  end
endmodule : embedded_fifo_element_tb_top
